// ===== hdl/ccr_bank.sv
// channel 1 and channel 2 configuration and calibration registers
// assumes strobes synchronous to clk, never both high at once
//
// Strobed register access was left to the implementer.
`default_nettype none
module ccr_bank
  import ccr_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic [ccr_pkg::ADDR_W-1:0] addr,
  input  wire logic [ccr_pkg::DATA_W-1:0] wrData,
  input  wire logic                 wrStb,
  input  wire logic                 rdStb,
  output logic [ccr_pkg::DATA_W-1:0] rdData,
  output logic [9:0]                chan1DelayField,
  output logic                      chan1DcFilterOff,
  output logic [1:0]                chan1InputSelect,
  output logic [9:0]                chan2DelayField,
  output logic                      chan2DcFilterOff,
  output logic [1:0]                chan2InputSelect,
  output logic [23:0]               chan1Offset,
  output logic [23:0]               chan1Gain,
  output logic [23:0]               chan2Offset
);
  import ccr_pkg::*;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [15:0] cfg1_q, cfg2_q;
  logic [15:0] ofs1Up_q, ofs1Lo_q, gain1Up_q, gain1Lo_q;
  logic [15:0] ofs2Up_q, ofs2Lo_q;
  logic [15:0] rdData_q, rdData_d;

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  // masking at write time keeps reserved bits zero with no read logic
  wire         wrCfg1   = wrStb && (addr == CHAN1_CONFIG);
  wire         wrOfs1Up = wrStb && (addr == CHAN1_OFS_UPPER);
  wire         wrOfs1Lo = wrStb && (addr == CHAN1_OFS_LOWER);
  wire         wrGn1Up  = wrStb && (addr == CHAN1_GAIN_UPPER);
  wire         wrGn1Lo  = wrStb && (addr == CHAN1_GAIN_LOWER);
  wire         wrCfg2   = wrStb && (addr == CHAN2_CONFIG);
  wire         wrOfs2Up = wrStb && (addr == CHAN2_OFS_UPPER);
  wire         wrOfs2Lo = wrStb && (addr == CHAN2_OFS_LOWER);
  wire [15:0]  cfgWr    = wrData & CFG_WMASK;
  wire [15:0]  lowerWr  = wrData & LOWER_WMASK;

  // config registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg1_q <= CFG_RESET;
      cfg2_q <= CFG_RESET;
    end else begin
      if (wrCfg1) cfg1_q <= cfgWr;
      if (wrCfg2) cfg2_q <= cfgWr;
    end
  end

  // offset registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ofs1Up_q <= OFS_RESET;
      ofs1Lo_q <= OFS_RESET;
      ofs2Up_q <= OFS_RESET;
      ofs2Lo_q <= OFS_RESET;
    end else begin
      if (wrOfs1Up) ofs1Up_q <= wrData;
      if (wrOfs1Lo) ofs1Lo_q <= lowerWr;
      if (wrOfs2Up) ofs2Up_q <= wrData;
      if (wrOfs2Lo) ofs2Lo_q <= lowerWr;
    end
  end

  // gain registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gain1Up_q <= GAIN_UP_RESET;
      gain1Lo_q <= GAIN_LO_RESET;
    end else begin
      if (wrGn1Up) gain1Up_q <= wrData;
      if (wrGn1Lo) gain1Lo_q <= lowerWr;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // unmapped addresses read zero; data shows only the cycle after
  always_comb begin
    rdData_d = READ_UNMAPPED;
    if (rdStb) begin
      unique case (addr)
        CHAN1_CONFIG:     rdData_d = cfg1_q;
        CHAN1_OFS_UPPER:  rdData_d = ofs1Up_q;
        CHAN1_OFS_LOWER:  rdData_d = ofs1Lo_q;
        CHAN1_GAIN_UPPER: rdData_d = gain1Up_q;
        CHAN1_GAIN_LOWER: rdData_d = gain1Lo_q;
        CHAN2_CONFIG:     rdData_d = cfg2_q;
        CHAN2_OFS_UPPER:  rdData_d = ofs2Up_q;
        CHAN2_OFS_LOWER:  rdData_d = ofs2Lo_q;
        default:          rdData_d = READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rdData_q <= READ_UNMAPPED;
    else         rdData_q <= rdData_d;
  end
  assign rdData = rdData_q;

  // ----------------------------------------------------------------
  // field outputs
  // ----------------------------------------------------------------
  // one splitter per channel; arrays carry words in and fields out
  logic [15:0] cfgWord  [2];
  logic [9:0]  delayOut [2];
  logic        dcOffOut [2];
  logic [1:0]  selOut   [2];
  assign cfgWord[0] = cfg1_q;
  assign cfgWord[1] = cfg2_q;

  // same layout on both channels, so one loop serves both
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    ccr_cfg_if cfgBus ();
    assign cfgBus.word  = cfgWord[ch];
    assign delayOut[ch] = cfgBus.delay;
    assign dcOffOut[ch] = cfgBus.dcOff;
    assign selOut[ch]   = cfgBus.sel;
    ccr_cfg_split u_split (
      .cfg(cfgBus)
    );
  end

  // fields are plain slices of flops, so outputs stay flop-driven
  assign chan1DelayField  = delayOut[0];
  assign chan1DcFilterOff = dcOffOut[0];
  assign chan1InputSelect = selOut[0];
  assign chan2DelayField  = delayOut[1];
  assign chan2DcFilterOff = dcOffOut[1];
  assign chan2InputSelect = selOut[1];
  // 24-bit values join upper word with lower byte
  assign chan1Offset = {ofs1Up_q, ofs1Lo_q[15:8]};
  assign chan1Gain   = {gain1Up_q, gain1Lo_q[15:8]};
  assign chan2Offset = {ofs2Up_q, ofs2Lo_q[15:8]};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  cfg_resv_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
    (cfg1_q[5:3] == 3'h0) && (cfg2_q[5:3] == 3'h0))
    else $error("config reserved bits not zero");

  lower_byte_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
    (ofs1Lo_q[7:0] == 8'h00) && (ofs2Lo_q[7:0] == 8'h00) && (gain1Lo_q[7:0] == 8'h00))
    else $error("lower calibration low byte not zero");

  delay_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    wrCfg1 |=> chan1DelayField == $past(wrData[15:6]))
    else $error("channel 1 delay not stored");

  dc_off_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    wrCfg1 |=> chan1DcFilterOff == $past(wrData[2]))
    else $error("channel 1 dc filter bit not stored");

  sel_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    wrCfg1 |=> chan1InputSelect == $past(wrData[1:0]))
    else $error("channel 1 input select not stored");

  cfg2_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    wrCfg2 |=> cfg2_q == {$past(wrData[15:6]), 3'h0, $past(wrData[2:0])})
    else $error("channel 2 config not stored");

  ofs_upper_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    (wrOfs1Up ##1 (rdStb && addr == CHAN1_OFS_UPPER && !wrStb))
      |=> rdData == $past(wrData, 2))
    else $error("offset upper readback wrong");

  gain_value_a: assert property (@(posedge clk) disable iff (!arst_n)
    wrGn1Up |=> chan1Gain[23:8] == $past(wrData))
    else $error("gain upper not stored");

  gain_lower_a: assert property (@(posedge clk) disable iff (!arst_n)
    wrGn1Lo |=> chan1Gain[7:0] == $past(wrData[15:8]))
    else $error("gain lower not stored");

  resv_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    (wrCfg1 && wrData[5:3] != 3'h0) |=> cfg1_q[15:6] == $past(wrData[15:6]))
    else $error("field update lost on reserved write");

  read_once_a: assert property (@(posedge clk) disable iff (!arst_n)
    !rdStb |=> rdData == 16'h0000)
    else $error("read data present without read");

  // ----------------------------------------------------------------
  // reset value checks
  // ----------------------------------------------------------------
  // no disable here: these look at the first edge after release
  reset_cfg_a: assert property (@(posedge clk)
    $rose(arst_n) |-> (cfg1_q == CFG_RESET) && (cfg2_q == CFG_RESET))
    else $error("config not at reset value after reset");

  reset_ofs_a: assert property (@(posedge clk)
    $rose(arst_n) |-> (chan1Offset == 24'h000000) && (chan2Offset == 24'h000000))
    else $error("offset not zero after reset");

  reset_gain_a: assert property (@(posedge clk)
    $rose(arst_n) |-> (gain1Up_q == GAIN_UP_RESET) && (gain1Lo_q == GAIN_LO_RESET))
    else $error("gain not at reset value after reset");

  // ----------------------------------------------------------------
  // write isolation checks
  // ----------------------------------------------------------------
  // a decode slip would let one write land in a neighbour
  cfg1_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !wrCfg1 |=> $stable(cfg1_q))
    else $error("channel 1 config changed without a write");

  cfg2_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !wrCfg2 |=> $stable(cfg2_q))
    else $error("channel 2 config changed without a write");

  ofs1_up_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !wrOfs1Up |=> $stable(ofs1Up_q))
    else $error("channel 1 offset upper changed without a write");

  ofs1_lo_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !wrOfs1Lo |=> $stable(ofs1Lo_q))
    else $error("channel 1 offset lower changed without a write");

  gain_up_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !wrGn1Up |=> $stable(gain1Up_q))
    else $error("gain upper changed without a write");

  gain_lo_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !wrGn1Lo |=> $stable(gain1Lo_q))
    else $error("gain lower changed without a write");

  ofs2_up_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !wrOfs2Up |=> $stable(ofs2Up_q))
    else $error("channel 2 offset upper changed without a write");

  ofs2_lo_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !wrOfs2Lo |=> $stable(ofs2Lo_q))
    else $error("channel 2 offset lower changed without a write");

  // ----------------------------------------------------------------
  // read path checks
  // ----------------------------------------------------------------
  // strobes never overlap, so the stored word cannot move under a read
  rd_cfg1_a: assert property (@(posedge clk) disable iff (!arst_n)
    (rdStb && addr == CHAN1_CONFIG) |=> rdData == $past(cfg1_q))
    else $error("channel 1 config read wrong");

  rd_ofs1_up_a: assert property (@(posedge clk) disable iff (!arst_n)
    (rdStb && addr == CHAN1_OFS_UPPER) |=> rdData == $past(ofs1Up_q))
    else $error("channel 1 offset upper read wrong");

  rd_ofs1_lo_a: assert property (@(posedge clk) disable iff (!arst_n)
    (rdStb && addr == CHAN1_OFS_LOWER) |=> rdData == $past(ofs1Lo_q))
    else $error("channel 1 offset lower read wrong");

  rd_gain_up_a: assert property (@(posedge clk) disable iff (!arst_n)
    (rdStb && addr == CHAN1_GAIN_UPPER) |=> rdData == $past(gain1Up_q))
    else $error("gain upper read wrong");

  rd_gain_lo_a: assert property (@(posedge clk) disable iff (!arst_n)
    (rdStb && addr == CHAN1_GAIN_LOWER) |=> rdData == $past(gain1Lo_q))
    else $error("gain lower read wrong");

  rd_cfg2_a: assert property (@(posedge clk) disable iff (!arst_n)
    (rdStb && addr == CHAN2_CONFIG) |=> rdData == $past(cfg2_q))
    else $error("channel 2 config read wrong");

  rd_ofs2_up_a: assert property (@(posedge clk) disable iff (!arst_n)
    (rdStb && addr == CHAN2_OFS_UPPER) |=> rdData == $past(ofs2Up_q))
    else $error("channel 2 offset upper read wrong");

  rd_ofs2_lo_a: assert property (@(posedge clk) disable iff (!arst_n)
    (rdStb && addr == CHAN2_OFS_LOWER) |=> rdData == $past(ofs2Lo_q))
    else $error("channel 2 offset lower read wrong");

  // ----------------------------------------------------------------
  // field update checks
  // ----------------------------------------------------------------
  // outputs are what the datapath sees, so check them, not the flops
  cfg2_fields_a: assert property (@(posedge clk) disable iff (!arst_n)
    wrCfg2 |=> (chan2DelayField == $past(wrData[15:6]))
      && (chan2DcFilterOff == $past(wrData[2]))
      && (chan2InputSelect == $past(wrData[1:0])))
    else $error("channel 2 fields not stored");

  cfg2_resv_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    (wrCfg2 && wrData[5:3] != 3'h0) |=> chan2DelayField == $past(wrData[15:6]))
    else $error("channel 2 field update lost on reserved write");

  ofs1_up_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    wrOfs1Up |=> chan1Offset[23:8] == $past(wrData))
    else $error("channel 1 offset upper not stored");

  ofs1_lo_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    wrOfs1Lo |=> chan1Offset[7:0] == $past(wrData[15:8]))
    else $error("channel 1 offset lower not stored");

  ofs2_up_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    wrOfs2Up |=> chan2Offset[23:8] == $past(wrData))
    else $error("channel 2 offset upper not stored");

  ofs2_lo_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    wrOfs2Lo |=> chan2Offset[7:0] == $past(wrData[15:8]))
    else $error("channel 2 offset lower not stored");
endmodule : ccr_bank
`default_nettype wire

// ===== hdl/ccr_pkg.sv
// constants and types for the channel config and calibration register bank
// assumes one 40 MHz clock and a plain strobed register port
// Notes on behaviour
// - phase delay sits in config bits 15:6
// - bit 2 set disables dc filter per channel
// - bits 1:0 pick the converter input source
// - channel 2 config mirrors channel 1 layout
// - channel 1 config resets to zero
// - upper offset word holds bits 23:8, resets zero
// - lower offset byte in 15:8, 7:0 zero
// - upper gain word resets to 8000h
// - lower gain keeps bits 7:0 zero, resets zero
// - config bits 5:3 always read zero
`default_nettype none
package ccr_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 6;
  localparam int          DATA_W          = 16;
  localparam logic [5:0]  CHAN1_CONFIG    = 6'h0E;
  localparam logic [5:0]  CHAN1_OFS_UPPER = 6'h0F;
  localparam logic [5:0]  CHAN1_OFS_LOWER = 6'h10;
  localparam logic [5:0]  CHAN1_GAIN_UPPER = 6'h11;
  localparam logic [5:0]  CHAN1_GAIN_LOWER = 6'h12;
  localparam logic [5:0]  CHAN2_CONFIG    = 6'h13;
  localparam logic [5:0]  CHAN2_OFS_UPPER = 6'h14;
  localparam logic [5:0]  CHAN2_OFS_LOWER = 6'h15;
  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int          DELAY_LSB       = 6;
  localparam int          DELAY_W         = 10;
  localparam int          DCOFF_BIT       = 2;
  localparam int          SEL_W           = 2;
  localparam logic [15:0] CFG_WMASK       = 16'hFFC7;
  localparam logic [15:0] LOWER_WMASK     = 16'hFF00;
  localparam logic [15:0] CFG_RESET       = 16'h0000;
  localparam logic [15:0] OFS_RESET       = 16'h0000;
  localparam logic [15:0] GAIN_UP_RESET   = 16'h8000;
  localparam logic [15:0] GAIN_LO_RESET   = 16'h0000;
  localparam logic [15:0] READ_UNMAPPED   = 16'h0000;
  // input selector codes
  typedef enum logic [1:0] {
    CCR_SEL_OWN_PAIR = 2'h0,
    CCR_SEL_SHORTED  = 2'h1,
    CCR_SEL_POS_TEST = 2'h2,
    CCR_SEL_NEG_TEST = 2'h3
  } ccr_sel_e;
endpackage : ccr_pkg
`default_nettype wire

// ===== hdl/ccr_cfg_if.sv
// bundle carrying one channel's decoded configuration fields
// assumes driver is the register bank, reader the field splitter
`default_nettype none
interface ccr_cfg_if;
  logic [15:0] word;
  logic [9:0]  delay;
  logic        dcOff;
  logic [1:0]  sel;
  modport src (output word, input delay, dcOff, sel);
  modport dec (input word, output delay, dcOff, sel);
endinterface : ccr_cfg_if
`default_nettype wire

// ===== hdl/ccr_cfg_split.sv
// splits a stored config word into its fields
// assumes the word already has reserved bits cleared
`default_nettype none
module ccr_cfg_split
  import ccr_pkg::*;
(
  ccr_cfg_if.dec cfg
);
  // ----------------------------------------------------------------
  // field extraction
  // ----------------------------------------------------------------
  assign cfg.delay = cfg.word[DELAY_LSB +: DELAY_W];
  assign cfg.dcOff = cfg.word[DCOFF_BIT];
  assign cfg.sel   = cfg.word[SEL_W-1:0];
endmodule : ccr_cfg_split
`default_nettype wire

// ===== test/ccr_bank_tb.sv
// self-checking bench for the channel config and calibration register bank
// assumes ccr_pkg and ccr_bank compiled first; bench drives the strobed port itself
`default_nettype none
module ccr_bank_tb
  import ccr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // stimulus and observation signals
  // ----------------------------------------------------------------
  logic                clk      = 1'b0;
  logic                arstN    = 1'b0;
  logic [ADDR_W-1:0]   addr     = '0;
  logic [DATA_W-1:0]   wrData   = '0;
  logic                wrStb    = 1'b0;
  logic                rdStb    = 1'b0;
  logic [DATA_W-1:0]   rdData;
  logic [9:0]          chan1DelayField, chan2DelayField;
  logic                chan1DcFilterOff, chan2DcFilterOff;
  logic [1:0]          chan1InputSelect, chan2InputSelect;
  logic [23:0]         chan1Offset, chan1Gain, chan2Offset;
  int                  miscompares = 0;
  int                  cmpCount    = 0;

  // 25 ns period, 40 MHz
  always #12.5 clk = ~clk;

  ccr_bank ccr_bank_i (
    .clk(clk), .arst_n(arstN), .addr(addr), .wrData(wrData), .wrStb(wrStb),
    .rdStb(rdStb), .rdData(rdData), .chan1DelayField(chan1DelayField),
    .chan1DcFilterOff(chan1DcFilterOff), .chan1InputSelect(chan1InputSelect),
    .chan2DelayField(chan2DelayField), .chan2DcFilterOff(chan2DcFilterOff),
    .chan2InputSelect(chan2InputSelect), .chan1Offset(chan1Offset),
    .chan1Gain(chan1Gain), .chan2Offset(chan2Offset)
  );
  // ----------------------------------------------------------------
  // shared bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // strobes move just after an edge, so the bank samples them cleanly on the next one
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    addr   <= a;
    wrData <= d;
    wrStb  <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
    #1;
  endtask : wr
  // read data stands only in the cycle after the strobe, then drops to zero
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    @(posedge clk);
    addr  <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 chk({8'h00, rdData}, {8'h00, e});
    @(posedge clk);
    #1 chk({8'h00, rdData}, 24'h000000);
  endtask : rd
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [15:0] exp [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h8000,
                             16'h0000, 16'h0000, 16'h0000, 16'h0000};
    chk(chan1Gain, 24'h800000);
    chk(chan1Offset | chan2Offset, 24'h000000);
    for (int i = 0; i < 8; i++) begin
      rd(6'h0E + 6'(i), exp[i]);
    end
    $display("test reset values done");
  endtask : t_reset
  // every selector code on both channels, reserved bits written as ones
  task automatic t_cfg;
    logic [9:0]  dlys [4] = '{10'h200, 10'h1FF, 10'h3FF, 10'h001};
    logic [15:0] d;
    logic [5:0]  a;
    for (int c = 0; c < 2; c++) begin
      for (int s = 0; s < 4; s++) begin
        a = (c == 1) ? 6'h13 : 6'h0E;
        d = {dlys[s], 3'b111, s[0], s[1:0]};
        wr(a, d);
        chk(24'((c == 1) ? chan2DelayField : chan1DelayField), 24'(dlys[s]));
        chk(24'((c == 1) ? chan2DcFilterOff : chan1DcFilterOff), 24'(s[0]));
        chk(24'((c == 1) ? chan2InputSelect : chan1InputSelect), 24'(s[1:0]));
        rd(a, {dlys[s], 3'b000, s[0], s[1:0]});
      end
    end
    $display("test config fields done");
  endtask : t_cfg
  // halves of the 24-bit values, low bytes of the offset lower words written as ones
  task automatic t_cal;
    wr(6'h0F, 16'hA55A);
    wr(6'h10, 16'h3CFF);
    wr(6'h11, 16'h7FFF);
    wr(6'h12, 16'hC3A5);
    wr(6'h14, 16'h1234);
    wr(6'h15, 16'h56FF);
    chk(chan1Offset, 24'hA55A3C);
    chk(chan1Gain, 24'h7FFFC3);
    chk(chan2Offset, 24'h123456);
    rd(6'h10, 16'h3C00);
    rd(6'h12, 16'hC300);
    rd(6'h15, 16'h5600);
    rd(6'h11, 16'h7FFF);
    wr(6'h10, 16'h0001);
    chk(chan1Offset, 24'hA55A00);
    $display("test calibration words done");
  endtask : t_cal
  // write then read with no gap, as the port allows back to back strobes
  task automatic t_b2b;
    @(posedge clk);
    addr   <= 6'h0F;
    wrData <= 16'h5AA5;
    wrStb  <= 1'b1;
    @(posedge clk);
    wrStb  <= 1'b0;
    rdStb  <= 1'b1;
    @(posedge clk);
    rdStb  <= 1'b0;
    #1 chk({8'h00, rdData}, 24'h005AA5);
    chk(chan1Offset, 24'h5AA500);
    @(posedge clk);
    #1 chk({8'h00, rdData}, 24'h000000);
    $display("test back to back strobes done");
  endtask : t_b2b
  // unmapped places neither store nor disturb channel 1 config next to 0Dh
  task automatic t_unmapped;
    wr(6'h0D, 16'hFFFF);
    wr(6'h16, 16'hFFFF);
    rd(6'h0D, 16'h0000);
    rd(6'h16, 16'h0000);
    rd(6'h0E, 16'h0047);
    $display("test unmapped access done");
  endtask : t_unmapped
  // ----------------------------------------------------------------
  // verdict and main sequence
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // watchdog so a stuck sequence still reaches the verdict
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    finish_test();
  end

  initial begin
    repeat (10) @(posedge clk);
    arstN <= 1'b1;
    #1;
    t_reset();
    t_cfg();
    t_cal();
    t_b2b();
    t_unmapped();
    @(posedge clk);
    arstN <= 1'b0;
    repeat (2) @(posedge clk);
    arstN <= 1'b1;
    #1;
    t_reset();
    finish_test();
  end
endmodule : ccr_bank_tb
`default_nettype wire
